/* rtl/cpu_bus_device.sv */
// processor end: single writes, four-longword burst writes, interrupt acknowledge
// assumes a responder on cpu_bus_if that holds its answer until data strobe drops
`timescale 1ns/1ps
`default_nettype none
module cpu_bus_device (
  // clock and reset
  input  wire logic                     ref_clk,
  input  wire logic                     reset_n,
  // bus
  cpu_bus_if.device                     bus,
  // request
  input  wire logic                     req_valid,
  output logic                          req_ready,
  input  wire cpu_bus_pkg::kind_t       req_kind,
  input  wire logic                     req_from_netcop,
  input  wire logic                     req_io_space,
  input  wire logic                     req_cctl,
  input  wire logic [31:0]              req_addr,
  input  wire logic [4:0]               req_status,
  input  wire logic [3:0][3:0]          req_masks,
  input  wire logic [3:0][31:0]         req_data,
  input  wire logic [4:0]               req_ipl,
  // outcome
  output logic                          bus_free,
  output logic                          cycle_done,
  output logic                          cycle_retry,
  output logic                          machine_check,
  output logic                          iack_valid,
  output logic                          iack_passive,
  output logic [13:0]                   iack_vector,
  output logic [4:0]                    iack_new_ipl
);
  import cpu_bus_pkg::*;

  // ****************************************
  // microcycle divider
  // ****************************************
  logic [MICRO_CNT_W-1:0] micro_cnt_reg;
  logic                   tick_reg;

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      micro_cnt_reg <= '0;
      tick_reg      <= 1'b0;
    end else begin
      tick_reg      <= (micro_cnt_reg == MICRO_LAST);
      micro_cnt_reg <= (micro_cnt_reg == MICRO_LAST) ? '0 : micro_cnt_reg + 1'b1;
    end
  end

  assign bus.phase_one_edge = tick_reg;

  // ****************************************
  // cycle sequencer
  // ****************************************
  typedef enum logic [2:0] {S_IDLE, S_ADDR, S_DATA, S_GAP, S_END} state_t;

  state_t           state_reg;
  kind_t            kind_reg;
  logic [1:0]       word_reg;
  logic             pend_reg;
  logic             berr_reg;
  logic [3:0][3:0]  masks_reg;
  logic [3:0][31:0] data_reg;
  logic [4:0]       ipl_reg;
  logic             res_retry_reg;
  logic             res_fail_reg;
  logic             ok_sample;
  logic             retry_sample;
  logic             err_sample;
  logic             skip_reg;
  logic             last_word;
  logic             iack_bad;
  kind_t            eff_kind;

  assign ok_sample    = tick_reg && !skip_reg && !bus.ready_n && bus.error_n;
  assign retry_sample = tick_reg && !skip_reg && !bus.ready_n && !bus.error_n;
  assign err_sample   = tick_reg && !skip_reg && bus.ready_n && !bus.error_n && pend_reg;
  assign last_word  = (kind_reg != KIND_BURST) || (word_reg == LAST_WORD);
  assign iack_bad   = bus.cycle_status_parity_lines[3:0]
                      != byte_parity(bus.muxed_addr_data_lines);
  assign req_ready  = (state_reg == S_IDLE) && tick_reg;
  assign bus_free   = (state_reg == S_IDLE);

  always_comb begin
    eff_kind = KIND_SINGLE;
    if (req_kind == KIND_IACK) begin
      eff_kind = KIND_IACK;
    end else if (req_kind == KIND_BURST && req_from_netcop && !req_io_space) begin
      eff_kind = KIND_BURST;
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_reg                 <= S_IDLE;
      kind_reg                  <= KIND_SINGLE;
      word_reg                  <= 2'h0;
      pend_reg                  <= 1'b0;
      skip_reg                  <= 1'b0;
      berr_reg                  <= 1'b0;
      masks_reg                 <= '0;
      data_reg                  <= '0;
      ipl_reg                   <= 5'h00;
      res_retry_reg             <= 1'b0;
      res_fail_reg              <= 1'b0;
      bus.dal_dev_out           <= 32'h0000_0000;
      bus.dal_dev_oe            <= 1'b0;
      bus.csdp_dev_out          <= 5'h1F;
      bus.csdp_dev_oe           <= 1'b0;
      bus.byte_lane_masks_n     <= 4'hF;
      bus.address_strobe_n      <= 1'b1;
      bus.data_strobe_n         <= 1'b1;
      bus.write_n               <= 1'b1;
      bus.parity_check_enable_n <= 1'b1;
      bus.cache_control_line_n  <= 1'b1;
      iack_vector               <= 14'h0000;
      iack_new_ipl              <= 5'h00;
    end else begin
      unique case (state_reg)
        S_IDLE: begin
          if (req_valid && tick_reg) begin
            kind_reg      <= eff_kind;
            word_reg      <= 2'h0;
            pend_reg      <= 1'b0;
            berr_reg      <= 1'b0;
            res_retry_reg <= 1'b0;
            res_fail_reg  <= 1'b0;
            masks_reg     <= req_masks;
            data_reg      <= req_data;
            ipl_reg       <= req_ipl;
            unique case (eff_kind)
              KIND_BURST: begin
                bus.dal_dev_out  <= {LEN_OCTAWORD, req_addr[29:4], 4'h0};
                bus.csdp_dev_out <= STATUS_BURST;
              end
              KIND_IACK: begin
                bus.dal_dev_out  <= {LEN_LONGWORD, 23'h000000, req_ipl, 2'h0};
                bus.csdp_dev_out <= req_status;
              end
              default: begin
                bus.dal_dev_out  <= {LEN_LONGWORD, req_addr[29:2], 2'h0};
                bus.csdp_dev_out <= req_status;
              end
            endcase
            bus.dal_dev_oe           <= 1'b1;
            bus.csdp_dev_oe          <= 1'b1;
            bus.byte_lane_masks_n    <= (eff_kind == KIND_IACK) ? 4'h0 : ~req_masks[0];
            bus.write_n              <= (eff_kind == KIND_IACK);
            bus.cache_control_line_n <= ~req_cctl;
            state_reg                <= S_ADDR;
          end
        end
        S_ADDR: begin
          bus.address_strobe_n <= 1'b0;
          if (tick_reg && !bus.address_strobe_n) begin
            if (kind_reg == KIND_IACK) begin
              bus.dal_dev_oe  <= 1'b0;
              bus.csdp_dev_oe <= 1'b0;
            end else begin
              bus.dal_dev_out           <= data_reg[0];
              bus.csdp_dev_out          <= {1'b1, byte_parity(data_reg[0])};
              bus.parity_check_enable_n <= 1'b0;
            end
            bus.data_strobe_n <= 1'b0;
            skip_reg          <= (kind_reg == KIND_BURST);
            state_reg         <= S_DATA;
          end
        end
        S_DATA: begin
          // burst words skip their first tick: two microcycles each
          if (ok_sample || retry_sample || err_sample) begin
            pend_reg <= 1'b0;
            if (ok_sample && kind_reg == KIND_IACK) begin
              iack_vector  <= bus.muxed_addr_data_lines[15:2];
              iack_new_ipl <= bus.muxed_addr_data_lines[0] ? IPL_FORCED : ipl_reg;
              res_fail_reg <= iack_bad;
            end
            if (!ok_sample && kind_reg == KIND_BURST) begin
              berr_reg <= 1'b1;
            end else if (retry_sample) begin
              res_retry_reg <= 1'b1;
            end else if (err_sample) begin
              res_fail_reg <= 1'b1;
            end
            bus.data_strobe_n <= 1'b1;
            if (last_word) begin
              bus.address_strobe_n <= 1'b1;
              state_reg            <= S_END;
            end else begin
              word_reg  <= word_reg + 2'h1;
              state_reg <= S_GAP;
            end
          end else if (tick_reg) begin
            pend_reg <= !skip_reg && bus.ready_n && !bus.error_n;
            skip_reg <= 1'b0;
          end
        end
        S_GAP: begin
          // wait for the previous answer to be withdrawn
          if (bus.ready_n && bus.error_n) begin
            bus.dal_dev_out       <= data_reg[word_reg];
            bus.csdp_dev_out      <= {1'b1, byte_parity(data_reg[word_reg])};
            bus.byte_lane_masks_n <= berr_reg ? NO_BYTES_N : ~masks_reg[word_reg];
            bus.data_strobe_n     <= 1'b0;
            skip_reg              <= 1'b1;
            state_reg             <= S_DATA;
          end
        end
        S_END: begin
          bus.dal_dev_oe            <= 1'b0;
          bus.csdp_dev_oe           <= 1'b0;
          bus.byte_lane_masks_n     <= 4'hF;
          bus.write_n               <= 1'b1;
          bus.parity_check_enable_n <= 1'b1;
          bus.cache_control_line_n  <= 1'b1;
          state_reg                 <= S_IDLE;
        end
        default: begin
          state_reg <= S_IDLE;
        end
      endcase
    end
  end

  // ****************************************
  // outcome pulses
  // ****************************************
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      cycle_done    <= 1'b0;
      cycle_retry   <= 1'b0;
      machine_check <= 1'b0;
      iack_valid    <= 1'b0;
      iack_passive  <= 1'b0;
    end else begin
      cycle_done    <= (state_reg == S_END);
      cycle_retry   <= (state_reg == S_END) && res_retry_reg;
      machine_check <= (state_reg == S_END) && res_fail_reg
                       && (kind_reg == KIND_SINGLE);
      iack_valid    <= (state_reg == S_END) && (kind_reg == KIND_IACK)
                       && !res_fail_reg && !res_retry_reg;
      iack_passive  <= (state_reg == S_END) && (kind_reg == KIND_IACK)
                       && res_fail_reg;
    end
  end

endmodule // cpu_bus_device
`default_nettype wire

/* rtl/cpu_bus_pkg.sv */
// shared constants and types for the processor write / interrupt acknowledge bus
// assumes one clock at 250 MHz; bus control lines are active low
package cpu_bus_pkg;

  // ****************************************
  // timing
  // ****************************************
  localparam int CLK_PERIOD_NS = 4;
  localparam int MICROCYCLE_NS = 100;
  localparam int MICRO_CLKS    = (MICROCYCLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int MICRO_CNT_W   = 5;
  localparam logic [MICRO_CNT_W-1:0] MICRO_LAST = MICRO_CNT_W'(MICRO_CLKS - 1);
  localparam logic [1:0] CCTL_WAIT_STATES = 2'h2;

  // ****************************************
  // address and status encodings
  // ****************************************
  localparam logic [1:0] LEN_LONGWORD = 2'h1;
  localparam logic [1:0] LEN_OCTAWORD = 2'h3;
  localparam logic [4:0] STATUS_BURST = 5'h17;
  localparam logic [4:0] IPL_FORCED   = 5'h17;
  localparam logic [1:0] LAST_WORD    = 2'h3;
  localparam logic [3:0] NO_BYTES_N   = 4'hF;

  // ****************************************
  // types
  // ****************************************
  typedef enum logic [1:0] {KIND_SINGLE, KIND_BURST, KIND_IACK} kind_t;
  typedef enum logic [1:0] {RESP_OK, RESP_ERR, RESP_RETRY} resp_t;

  function automatic logic [3:0] byte_parity(input logic [31:0] d);
    logic [3:0] p;
    p = 4'h0;
    for (int i = 0; i < 4; i++) begin
      p[i] = ^d[8*i +: 8];
    end
    return p;
  endfunction

endpackage

/* rtl/cpu_bus_if.sv */
// bus wires between the processor end and the responder end
// assumes both ends run on the same ref_clk; two-way lines resolved here
`timescale 1ns/1ps
`default_nettype none
interface cpu_bus_if;

  // device driven
  logic [31:0] dal_dev_out;
  logic        dal_dev_oe;
  logic [4:0]  csdp_dev_out;
  logic        csdp_dev_oe;
  logic [3:0]  byte_lane_masks_n;
  logic        address_strobe_n;
  logic        data_strobe_n;
  logic        write_n;
  logic        parity_check_enable_n;
  logic        cache_control_line_n;
  logic        phase_one_edge;
  // responder driven
  logic [31:0] dal_resp_out;
  logic        dal_resp_oe;
  logic [3:0]  csdp_resp_out;
  logic        csdp_resp_oe;
  logic        ready_n;
  logic        error_n;
  // resolved wires
  logic [31:0] muxed_addr_data_lines;
  logic [4:0]  cycle_status_parity_lines;

  assign muxed_addr_data_lines = dal_dev_oe ? dal_dev_out :
                                 (dal_resp_oe ? dal_resp_out : 32'h0000_0000);
  assign cycle_status_parity_lines = csdp_dev_oe ? csdp_dev_out :
                                     {1'b1, (csdp_resp_oe ? csdp_resp_out : 4'hF)};

  modport device (
    output dal_dev_out, dal_dev_oe, csdp_dev_out, csdp_dev_oe, byte_lane_masks_n,
    output address_strobe_n, data_strobe_n, write_n, parity_check_enable_n,
    output cache_control_line_n, phase_one_edge,
    input  ready_n, error_n, muxed_addr_data_lines, cycle_status_parity_lines
  );

  modport responder (
    output dal_resp_out, dal_resp_oe, csdp_resp_out, csdp_resp_oe, ready_n, error_n,
    input  byte_lane_masks_n, address_strobe_n, data_strobe_n, write_n,
    input  parity_check_enable_n, cache_control_line_n, phase_one_edge,
    input  muxed_addr_data_lines, cycle_status_parity_lines
  );

endinterface // cpu_bus_if
`default_nettype wire

/* rtl/cpu_bus_responder.sv */
// responder end: memory / I/O write sink and interrupt vector source
// assumes the processor end on cpu_bus_if supplies phase_one_edge
`timescale 1ns/1ps
`default_nettype none
module cpu_bus_responder (
  // clock and reset
  input  wire logic                 ref_clk,
  input  wire logic                 reset_n,
  // bus
  cpu_bus_if.responder              bus,
  // answer control
  input  wire cpu_bus_pkg::resp_t   resp_mode,
  input  wire logic                 extra_wait,
  input  wire logic [13:0]          vector_offset,
  input  wire logic                 vector_force_ipl,
  // captured writes
  output logic                      wr_strobe,
  output logic [31:0]               wr_addr,
  output logic [31:0]               wr_data,
  output logic [3:0]                wr_bytes,
  // acknowledge seen
  output logic                      iack_taken,
  output logic [4:0]                iack_level
);
  import cpu_bus_pkg::*;

  logic       as_prev_reg;
  logic       ds_prev_reg;
  logic [31:0] addr_reg;
  logic       write_reg;
  logic       burst_reg;
  logic       cctl_reg;
  logic [1:0] word_reg;
  logic [1:0] wait_reg;
  logic       busy_reg;
  logic       done_reg;
  logic [31:0] vec_word;
  resp_t      mode;

  assign vec_word = {16'h0000, vector_offset, 1'b0, vector_force_ipl};
  // bursts are never retried
  assign mode = (burst_reg && resp_mode == RESP_RETRY) ? RESP_ERR : resp_mode;

  // ****************************************
  // address capture and answer
  // ****************************************
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      as_prev_reg       <= 1'b1;
      ds_prev_reg       <= 1'b1;
      addr_reg          <= 32'h0000_0000;
      write_reg         <= 1'b0;
      burst_reg         <= 1'b0;
      cctl_reg          <= 1'b0;
      word_reg          <= 2'h0;
      wait_reg          <= 2'h0;
      busy_reg          <= 1'b0;
      done_reg          <= 1'b0;
      bus.ready_n       <= 1'b1;
      bus.error_n       <= 1'b1;
      bus.dal_resp_out  <= 32'h0000_0000;
      bus.dal_resp_oe   <= 1'b0;
      bus.csdp_resp_out <= 4'hF;
      bus.csdp_resp_oe  <= 1'b0;
      wr_strobe         <= 1'b0;
      wr_addr           <= 32'h0000_0000;
      wr_data           <= 32'h0000_0000;
      wr_bytes          <= 4'h0;
      iack_taken        <= 1'b0;
      iack_level        <= 5'h00;
    end else begin
      as_prev_reg <= bus.address_strobe_n;
      ds_prev_reg <= bus.data_strobe_n;
      wr_strobe   <= 1'b0;
      iack_taken  <= 1'b0;
      if (as_prev_reg && !bus.address_strobe_n) begin
        addr_reg  <= bus.muxed_addr_data_lines;
        write_reg <= !bus.write_n;
        burst_reg <= bus.muxed_addr_data_lines[31:30] == LEN_OCTAWORD;
        cctl_reg  <= !bus.cache_control_line_n;
        word_reg  <= 2'h0;
      end
      if (ds_prev_reg && !bus.data_strobe_n) begin
        busy_reg <= 1'b1;
        done_reg <= 1'b0;
        wait_reg <= (cctl_reg && write_reg && !burst_reg) ? CCTL_WAIT_STATES
                    : {1'b0, extra_wait};
      end else if (bus.data_strobe_n) begin
        busy_reg          <= 1'b0;
        bus.ready_n       <= 1'b1;
        bus.error_n       <= 1'b1;
        bus.dal_resp_oe   <= 1'b0;
        bus.csdp_resp_oe  <= 1'b0;
        if (!ds_prev_reg && burst_reg) begin
          word_reg <= word_reg + 2'h1;
        end
      end else if (busy_reg && !done_reg) begin
        if (wait_reg != 2'h0) begin
          if (bus.phase_one_edge) begin
            wait_reg <= wait_reg - 2'h1;
          end
        end else begin
          done_reg    <= 1'b1;
          bus.ready_n <= (mode == RESP_ERR);
          bus.error_n <= (mode == RESP_OK);
          if (write_reg && mode == RESP_OK) begin
            wr_strobe <= 1'b1;
            wr_addr   <= {addr_reg[31:4], (burst_reg ? word_reg : addr_reg[3:2]), 2'h0};
            wr_data   <= bus.muxed_addr_data_lines;
            wr_bytes  <= ~bus.byte_lane_masks_n;
          end
          if (!write_reg) begin
            bus.dal_resp_out  <= vec_word;
            bus.dal_resp_oe   <= 1'b1;
            bus.csdp_resp_out <= byte_parity(vec_word);
            bus.csdp_resp_oe  <= 1'b1;
            iack_taken        <= (mode == RESP_OK);
            iack_level        <= addr_reg[6:2];
          end
        end
      end
    end
  end

endmodule // cpu_bus_responder
`default_nettype wire

/* bench/cpu_bus_properties.sv */
// checker for the processor bus between the two ends
// assumes the bench wires the interface signals in by name
`timescale 1ns/1ps
`default_nettype none
module cpu_bus_properties (
  // clock and reset
  input wire logic        ref_clk,
  input wire logic        reset_n,
  // bus
  input wire logic [31:0] muxed_addr_data_lines,
  input wire logic [4:0]  cycle_status_parity_lines,
  input wire logic [3:0]  byte_lane_masks_n,
  input wire logic        address_strobe_n,
  input wire logic        data_strobe_n,
  input wire logic        write_n,
  input wire logic        parity_check_enable_n,
  input wire logic        phase_one_edge,
  input wire logic        ready_n,
  input wire logic        error_n
);
  import cpu_bus_pkg::*;
  logic [31:0] d;
  logic        err_seen_reg;
  assign d = muxed_addr_data_lines;
  // error answered on an earlier word of this cycle
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) err_seen_reg <= 1'b0;
    else if (address_strobe_n) err_seen_reg <= 1'b0;
    else if (!error_n && ready_n && !data_strobe_n) err_seen_reg <= 1'b1;
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  property p_frame; $fell(address_strobe_n) |-> d[1:0] == 2'h0 && d[31:30] inside {2'h1, 2'h3}; endproperty
  a_frame: assert property (p_frame) else $error("bad address frame");
  property p_setup; $fell(address_strobe_n) |-> $stable(write_n) && $stable(byte_lane_masks_n) && $stable(d); endproperty
  a_setup: assert property (p_setup) else $error("lines moved at strobe");
  property p_burst; $fell(address_strobe_n) && d[31:30] == 2'h3 |-> d[3:2] == 2'h0 && !write_n && cycle_status_parity_lines == 5'h17; endproperty
  a_burst: assert property (p_burst) else $error("bad burst address phase");
  property p_iack; $fell(address_strobe_n) && write_n |-> d[31:30] == 2'h1 && d[29:7] == 23'h0; endproperty
  a_iack: assert property (p_iack) else $error("bad acknowledge address");
  property p_data; $fell(data_strobe_n) && !write_n |-> !parity_check_enable_n && cycle_status_parity_lines == {1'b1, ^d[31:24], ^d[23:16], ^d[15:8], ^d[7:0]}; endproperty
  a_data: assert property (p_data) else $error("bad write data phase");
  property p_nest; !data_strobe_n |-> !address_strobe_n; endproperty
  a_nest: assert property (p_nest) else $error("data strobe outside address strobe");
  property p_end; $rose(address_strobe_n) |-> data_strobe_n && (!$past(ready_n) || !$past(error_n)); endproperty
  a_end: assert property (p_end) else $error("cycle ended without answer");
  property p_tick; phase_one_edge |=> !phase_one_edge[*8] ##17 phase_one_edge; endproperty
  a_tick: assert property (p_tick) else $error("sample tick spacing");
  property p_err_masks; $fell(data_strobe_n) && err_seen_reg |-> byte_lane_masks_n == 4'hF; endproperty
  a_err_masks: assert property (p_err_masks) else $error("bytes written after error");
endmodule // cpu_bus_properties
`default_nettype wire

/* bench/tb_cpu_bus_write_and_iack_cycles.sv */
// self-checking bench: processor end facing responder end
// assumes design files and checker compiled first
`timescale 1ns/1ps
`default_nettype none
module tb_cpu_bus_write_and_iack_cycles;
  import cpu_bus_pkg::*;
  logic             ref_clk = 1'b0, reset_n = 1'b0, req_valid = 1'b0, netcop = 1'b0;
  logic             io_sp = 1'b0, cctl = 1'b0, extra = 1'b0, frc = 1'b0;
  kind_t            kind = KIND_SINGLE;
  resp_t            mode = RESP_OK;
  logic [31:0]      addr = 32'h0123_4560;
  logic [4:0]       interrupt_priority_level = 5'h0B;
  logic [13:0]      vec = 14'h1A5C;
  logic [3:0][3:0]  msk = 16'h5F3A;
  logic [3:0][31:0] dat = 128'h89AB_CDEF_0246_8ACE_1357_9BDF_FEDC_BA98;
  logic             rdy, free, done, rtr, mchk, iv, ipas, wrs, itk;
  logic [13:0]      ivec;
  logic [4:0]       nipl, ilvl, seen;
  logic [31:0]      wa, wd, qa[$], qd[$];
  logic [3:0]       wb, qb[$];
  int               num_errors = 0, n_compared = 0, cyc = 0, dur, d0, ttake, tdone, ntk = 0;
  always #2 ref_clk = ~ref_clk;
  cpu_bus_if bus ();
  cpu_bus_device i_cpu_bus_device (.ref_clk(ref_clk), .reset_n(reset_n), .bus(bus.device),
    .req_valid(req_valid), .req_ready(rdy), .req_kind(kind), .req_from_netcop(netcop),
    .req_io_space(io_sp), .req_cctl(cctl), .req_addr(addr), .req_status(5'h1F),
    .req_masks(msk), .req_data(dat), .req_ipl(interrupt_priority_level), .bus_free(free), .cycle_done(done),
    .cycle_retry(rtr), .machine_check(mchk), .iack_valid(iv), .iack_passive(ipas),
    .iack_vector(ivec), .iack_new_ipl(nipl));
  cpu_bus_responder i_cpu_bus_responder (.ref_clk(ref_clk), .reset_n(reset_n),
    .bus(bus.responder), .resp_mode(mode), .extra_wait(extra), .vector_offset(vec),
    .vector_force_ipl(frc), .wr_strobe(wrs), .wr_addr(wa), .wr_data(wd), .wr_bytes(wb),
    .iack_taken(itk), .iack_level(ilvl));
  cpu_bus_properties i_cpu_bus_properties (.ref_clk(ref_clk), .reset_n(reset_n),
    .muxed_addr_data_lines(bus.muxed_addr_data_lines),
    .cycle_status_parity_lines(bus.cycle_status_parity_lines),
    .byte_lane_masks_n(bus.byte_lane_masks_n), .address_strobe_n(bus.address_strobe_n),
    .data_strobe_n(bus.data_strobe_n), .write_n(bus.write_n),
    .parity_check_enable_n(bus.parity_check_enable_n),
    .phase_one_edge(bus.phase_one_edge), .ready_n(bus.ready_n), .error_n(bus.error_n));
  // ****************************************
  // monitor and checks
  // ****************************************
  always @(posedge ref_clk) begin
    cyc++;
    seen = seen | {done, rtr, mchk, ipas, iv};
    if (req_valid && rdy) ttake = cyc;
    if (done) tdone = cyc;
    if (itk) ntk++;
    if (wrs) begin
      qa.push_back(wa); qd.push_back(wd); qb.push_back(wb);
    end
    if (cyc > 20000) begin
      num_errors++;
      wrap_up();
    end
  end
  task automatic wrap_up();
    $display("compared %0d errors %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input logic [63:0] g, input logic [63:0] e);
    n_compared++;
    if (g !== e) begin
      num_errors++;
      $display("ERROR %0t: got %0h expected %0h", $time, g, e);
    end
  endtask
  // one cycle from request to done; ef = {retry, mcheck, passive, iack}
  task automatic go(input kind_t k, input logic nc, io, cc, x, input resp_t m,
                    input logic [3:0] ef, input int nw);
    int t;
    @(posedge ref_clk);
    kind <= k; netcop <= nc; io_sp <= io; cctl <= cc; extra <= x; mode <= m;
    req_valid <= 1'b1;
    #1 seen = 5'h00; ntk = 0; qa.delete(); qd.delete(); qb.delete();
    do @(posedge ref_clk); while (!rdy);
    req_valid <= 1'b0;
    for (t = 0; t < 3000 && !seen[4]; t++) begin
      @(posedge ref_clk);
      #1;
    end
    dur = tdone - ttake;
    chk(64'(seen), {59'h0, 1'b1, ef});
    if (nw >= 0) chk(64'(qa.size()), 64'(nw));
  endtask
  initial begin
    repeat (8) @(posedge ref_clk);
    reset_n <= 1'b1;
    go(KIND_SINGLE, 0, 0, 0, 0, RESP_OK, 4'h0, 1);
    d0 = dur;
    chk(64'(qa[0][29:2]), 64'(addr[29:2]));
    chk(64'(qd[0]), 64'(dat[0]));
    chk(64'(qb[0]), 64'(msk[0]));
    chk(64'(d0 >= 50), 64'h1);
    go(KIND_SINGLE, 0, 0, 0, 1, RESP_OK, 4'h0, 1);
    chk(64'(dur), 64'(d0 + 25));
    go(KIND_SINGLE, 0, 0, 1, 0, RESP_OK, 4'h0, 1);
    chk(64'(dur), 64'(d0 + 50));
    go(KIND_SINGLE, 0, 0, 0, 0, RESP_ERR, 4'h4, -1);
    go(KIND_SINGLE, 0, 0, 0, 0, RESP_RETRY, 4'h8, -1);
    chk(64'(free), 64'h1);
    go(KIND_BURST, 1, 0, 0, 0, RESP_OK, 4'h0, 4);
    chk(64'(dur >= 225), 64'h1);
    for (int i = 0; i < 4; i++) begin
      chk(64'(qa[i][29:2]), {36'h0, addr[29:4], 2'(i)});
      chk(64'(qd[i]), 64'(dat[i]));
      chk(64'(qb[i]), 64'(msk[i]));
    end
    go(KIND_BURST, 1, 1, 0, 0, RESP_OK, 4'h0, 1);
    go(KIND_BURST, 0, 0, 0, 0, RESP_OK, 4'h0, 1);
    go(KIND_BURST, 1, 0, 0, 0, RESP_ERR, 4'h0, -1);
    go(KIND_BURST, 1, 0, 0, 0, RESP_RETRY, 4'h0, -1);
    for (int i = 0; i < 2; i++) begin
      @(posedge ref_clk);
      frc <= i[0];
      go(KIND_IACK, 0, 0, 0, 0, RESP_OK, 4'h1, 0);
      chk(64'(ivec), 64'(vec));
      chk(64'(nipl), 64'(i ? 5'h17 : interrupt_priority_level));
      chk(64'(ilvl), 64'(interrupt_priority_level));
      chk(64'(ntk), 64'h1);
    end
    go(KIND_IACK, 0, 0, 0, 0, RESP_ERR, 4'h2, 0);
    chk(64'(ntk), 64'h0);
    wrap_up();
  end
endmodule // tb_cpu_bus_write_and_iack_cycles
`default_nettype wire
